// [core/emst_regs.vh]
`ifndef EMST_REGS_VH
`define EMST_REGS_VH

// Register byte offsets
`define EMST_OFS_NET_CTRL      8'h00
`define EMST_OFS_NET_CFG       8'h04
`define EMST_OFS_SA4_LOW       8'h08
`define EMST_OFS_SA4_HIGH      8'h0C
`define EMST_OFS_TYPE_MATCH    8'h10
`define EMST_OFS_USER_IO       8'h14
`define EMST_OFS_STAT_BASE     8'h18
`define EMST_STAT_COUNT        9

// Statistics counter indices (offset = base + 4 * index)
`define EMST_IDX_PAUSE_RX      0
`define EMST_IDX_TX_GOOD       1
`define EMST_IDX_ONE_COL       2
`define EMST_IDX_MANY_COL      3
`define EMST_IDX_RX_GOOD       4
`define EMST_IDX_CRC_ERR       5
`define EMST_IDX_ODD_BITS      6
`define EMST_IDX_DEFERRED      7
`define EMST_IDX_SLOT_OVR      8

// Field positions
`define EMST_CTRL_RX_EN_BIT    2
`define EMST_CTRL_STAT_WE_BIT  7
`define EMST_CFG_BIG_BIT       8
`define EMST_USRIO_RMII_BIT    0
`define EMST_USRIO_PHY_CLOCK_GATE_BIT   1

// Reset values
`define EMST_RST_NET_CTRL      32'h0000_0000
`define EMST_RST_NET_CFG       32'h0000_0000
`define EMST_RST_SA4_LOW       32'h0000_0000
`define EMST_RST_SA4_HIGH      16'h0000
`define EMST_RST_TYPE_MATCH    16'h0000
`define EMST_RST_USER_IO       2'h0

// Frame length limits in bytes
`define EMST_LEN_MIN           11'h040
`define EMST_LEN_MAX           11'h5EE
`define EMST_LEN_MAX_BIG       11'h600

// Collision limits
`define EMST_COL_MANY_MIN      5'h02
`define EMST_COL_MANY_MAX      5'h0F

`endif

// [core/emst_sync2.v]
`timescale 1ns/1ps
`default_nettype none

module emst_sync2 (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_b_i,
	input  wire ce_i,
	// Asynchronous level in, synchronised level out
	input  wire async_i,
	output reg  sync_o
);

	reg meta;

	// First stage feeds only the second stage
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta   <= 1'b0;
			sync_o <= 1'b0;
		end else if (ce_i) begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule

`default_nettype wire

// [core/emst_stat_counter.v]
`timescale 1ns/1ps
`default_nettype none

module emst_stat_counter #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        ce_i,
	// Control
	input  wire        inc_i,
	input  wire        clr_i,
	input  wire        wr_i,
	input  wire [23:0] wdata_i,
	// Value, zero above WIDTH
	output reg  [23:0] count_o
);

	wire [23:0] max_val = {24{1'b1}} >> (24 - WIDTH);
	wire        at_max  = (count_o == max_val);

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_o <= 24'h000000;
		end else if (ce_i) begin
			if (wr_i) begin
				count_o <= wdata_i & max_val;
			end else if (clr_i) begin
				// An event in the clearing cycle is kept as a count of one
				count_o <= inc_i ? 24'h000001 : 24'h000000; // (R1)
			end else if (inc_i && !at_max) begin
				count_o <= count_o + 24'h000001; // (R2)
			end
		end
	end

endmodule

`default_nettype wire

// [core/emst_top.v]
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "emst_regs.vh"

//Operation
// (R1) Reading a counter returns its value and then clears it to zero; an event in the read cycle is kept as a count of one.
// (R2) A counter at all ones holds there until a read clears it.
// (R3) Receive counters count only while receive enable is set.
// (R4) Counter writes take effect only while control bit 7 is set.
// (R5) Software should read counters often enough that none saturate.
// (R6) Address low bit 0 is the multicast bit of the first byte.
// (R7) The 16-bit type value is compared with each frame's type/length.
// (R8) User I/O bit 0 selects RMII when set, MII when clear.
// (R9) User I/O bit 1 lets the transceiver clock run; zero stops it.
// (R10) 16-bit count of good pause frames, 64 to 1518 bytes, no errors; up to 1536 bytes are counted while config bit 8 is set.
// (R11) 24-bit count of good copied frames; ceiling 1536 with config bit 8.
// (R12) 24-bit count of frames sent with no underrun and no retry failure.
// (R13) 16-bit count of frames sent after exactly one collision.
// (R14) 16-bit count of frames sent after two to fifteen collisions.
// (R15) 8-bit count of valid whole-byte frames with bad CRC or symbol error.
// (R16) 8-bit count of valid odd-bit frames with bad CRC or symbol error.
// (R17) 16-bit count of first-attempt deferrals without collision or underrun.
// (R18) 8-bit count of frames hit by a collision after the slot time.
// (R19) A late collision also counts as an ordinary collision.
// (R20) Address high word holds 16 bits; bits 31:16 read zero.
module emst_top (
	// Clock, reset, enable
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        ce_i,
	// Register port
	input  wire [7:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	// Receive frame report from the frame engine
	input  wire        rx_done_i,
	input  wire [10:0] rx_len_i,
	input  wire        rx_crc_bad_i,
	input  wire        rx_odd_bits_i,
	input  wire        rx_sym_err_i,
	input  wire        rx_pause_i,
	input  wire        rx_copied_i,
	input  wire [47:0] rx_dest_i,
	input  wire [15:0] rx_type_i,
	// Transmit frame report from the frame engine
	input  wire        tx_done_i,
	input  wire        tx_underrun_i,
	input  wire        tx_retry_fail_i,
	input  wire [4:0]  tx_collisions_i,
	input  wire        tx_late_col_i,
	input  wire        tx_deferred_i,
	// Match results
	output reg         match_valid_o,
	output reg         addr4_match_o,
	output reg         type_match_o,
	// Control outputs to the frame engine
	output reg         rx_enable_o,
	output reg         big_frames_o,
	// Transceiver side
	input  wire        phy_clk_i,
	output reg         rmii_mode_o,
	output reg         phy_clk_gated_o
);

	////////////////////////////////////////////////////////////////
	// Decode helpers

	// One-hot select of a statistics counter, zero when no counter is hit
	function [`EMST_STAT_COUNT-1:0] stat_sel;
		input [7:0] a;
		integer k;
		begin
			stat_sel = {`EMST_STAT_COUNT{1'b0}};
			for (k = 0; k < `EMST_STAT_COUNT; k = k + 1) begin
				if (a == `EMST_OFS_STAT_BASE + k[5:0] * 8'h04) begin
					stat_sel[k] = 1'b1;
				end
			end
		end
	endfunction

	// Width of each statistics counter
	function integer stat_width;
		input integer i;
		begin
			if (i == `EMST_IDX_TX_GOOD || i == `EMST_IDX_RX_GOOD) begin
				stat_width = 24;
			end else if (i == `EMST_IDX_CRC_ERR || i == `EMST_IDX_ODD_BITS ||
				i == `EMST_IDX_SLOT_OVR) begin
				stat_width = 8;
			end else begin
				stat_width = 16;
			end
		end
	endfunction

	// Control register select, shared by the write and the read chain
	localparam CTRL_NET  = 0;
	localparam CTRL_CFG  = 1;
	localparam CTRL_SA4L = 2;
	localparam CTRL_SA4H = 3;
	localparam CTRL_TYPE = 4;
	localparam CTRL_UIO  = 5;
	localparam CTRL_N    = 6;

	function [CTRL_N-1:0] ctrl_sel;
		input [7:0] a;
		begin
			ctrl_sel = {CTRL_N{1'b0}};
			if (a == `EMST_OFS_NET_CTRL) begin
				ctrl_sel[CTRL_NET] = 1'b1;
			end else if (a == `EMST_OFS_NET_CFG) begin
				ctrl_sel[CTRL_CFG] = 1'b1;
			end else if (a == `EMST_OFS_SA4_LOW) begin
				ctrl_sel[CTRL_SA4L] = 1'b1;
			end else if (a == `EMST_OFS_SA4_HIGH) begin
				ctrl_sel[CTRL_SA4H] = 1'b1;
			end else if (a == `EMST_OFS_TYPE_MATCH) begin
				ctrl_sel[CTRL_TYPE] = 1'b1;
			end else if (a == `EMST_OFS_USER_IO) begin
				ctrl_sel[CTRL_UIO] = 1'b1;
			end
		end
	endfunction

	// User I/O reset image, bits placed as in the register
	localparam [1:0] USER_IO_RST = `EMST_RST_USER_IO;

	////////////////////////////////////////////////////////////////
	// Control and configuration registers

	reg [31:0] net_ctrl;
	reg [31:0] net_cfg;
	reg [31:0] specific_addr4_low;
	reg [15:0] specific_addr4_high;
	reg [15:0] type_match_field;
	reg        rmii_sel;
	reg        phy_clock_gate;

	wire stat_we_en = net_ctrl[`EMST_CTRL_STAT_WE_BIT];
	wire rx_en      = net_ctrl[`EMST_CTRL_RX_EN_BIT];
	wire big_en     = net_cfg[`EMST_CFG_BIG_BIT];

	// Decoded once per cycle for both register paths
	wire [CTRL_N-1:0] ctrl_hit = ctrl_sel(addr_i);

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			net_ctrl            <= `EMST_RST_NET_CTRL;
			net_cfg             <= `EMST_RST_NET_CFG;
			specific_addr4_low  <= `EMST_RST_SA4_LOW;
			specific_addr4_high <= `EMST_RST_SA4_HIGH;
			type_match_field    <= `EMST_RST_TYPE_MATCH;
			rmii_sel            <= USER_IO_RST[`EMST_USRIO_RMII_BIT];
			phy_clock_gate      <= USER_IO_RST[`EMST_USRIO_PHY_CLOCK_GATE_BIT];
		end else if (ce_i && wr_i) begin
			// Only the 16-bit and user I/O registers drop upper bits here; control and config keep all 32
			if (ctrl_hit[CTRL_NET]) begin
				net_ctrl <= wdata_i;
			end else if (ctrl_hit[CTRL_CFG]) begin
				net_cfg <= wdata_i;
			end else if (ctrl_hit[CTRL_SA4L]) begin
				specific_addr4_low <= wdata_i; // (R6)
			end else if (ctrl_hit[CTRL_SA4H]) begin
				specific_addr4_high <= wdata_i[15:0]; // (R20)
			end else if (ctrl_hit[CTRL_TYPE]) begin
				type_match_field <= wdata_i[15:0]; // (R7)
			end else if (ctrl_hit[CTRL_UIO]) begin
				rmii_sel       <= wdata_i[`EMST_USRIO_RMII_BIT];
				phy_clock_gate <= wdata_i[`EMST_USRIO_PHY_CLOCK_GATE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Frame classification

	wire [10:0] len_max   = big_en ? `EMST_LEN_MAX_BIG : `EMST_LEN_MAX;
	wire        len_short = (rx_len_i < `EMST_LEN_MIN);
	wire        len_long  = (rx_len_i > len_max);
	wire        len_valid = !len_short && !len_long;
	wire        rx_clean  = !rx_crc_bad_i && !rx_odd_bits_i && !rx_sym_err_i;
	wire        rx_good   = len_valid && rx_clean;
	wire        rx_bad    = len_valid && (rx_crc_bad_i || rx_sym_err_i);
	wire        rx_event  = rx_done_i && rx_en; // (R3)

	// The late collision is reported apart and joins the ordinary tally
	wire [5:0]  col_total = {1'b0, tx_collisions_i} + {5'h00, tx_late_col_i}; // (R19)
	wire        tx_ok     = tx_done_i && !tx_underrun_i && !tx_retry_fail_i;
	wire        col_many  = (col_total >= {1'b0, `EMST_COL_MANY_MIN}) &&
		(col_total <= {1'b0, `EMST_COL_MANY_MAX});
	// A late collision is already in the total, so it also blocks a deferral count
	wire        col_none  = (col_total == 6'h00);
	wire        col_one   = (col_total == 6'h01);

	reg [`EMST_STAT_COUNT-1:0] stat_inc;

	always @* begin
		stat_inc = {`EMST_STAT_COUNT{1'b0}};
		// Receive tallies hold while receive enable is low
		stat_inc[`EMST_IDX_PAUSE_RX] = rx_event && rx_pause_i && rx_good; // (R10)
		stat_inc[`EMST_IDX_RX_GOOD]  = rx_event && rx_copied_i && rx_good; // (R11)
		stat_inc[`EMST_IDX_CRC_ERR]  = rx_event && rx_bad && !rx_odd_bits_i; // (R15)
		stat_inc[`EMST_IDX_ODD_BITS] = rx_event && rx_bad && rx_odd_bits_i; // (R16)

		// Transmit tallies ignore receive enable
		stat_inc[`EMST_IDX_TX_GOOD]  = tx_ok; // (R12)
		stat_inc[`EMST_IDX_ONE_COL]  = tx_ok && col_one; // (R13)
		stat_inc[`EMST_IDX_MANY_COL] = tx_ok && col_many; // (R14)
		stat_inc[`EMST_IDX_DEFERRED] = tx_done_i && tx_deferred_i &&
			!tx_underrun_i && col_none; // (R17)
		stat_inc[`EMST_IDX_SLOT_OVR] = tx_done_i && tx_late_col_i; // (R18)
	end

	////////////////////////////////////////////////////////////////
	// Statistics counters

	// One decode serves the clear, the write and the read data path
	wire [`EMST_STAT_COUNT-1:0] stat_hit = stat_sel(addr_i);
	wire [`EMST_STAT_COUNT-1:0] rd_sel   = rd_i ? stat_hit : {`EMST_STAT_COUNT{1'b0}};
	wire [`EMST_STAT_COUNT-1:0] wr_sel   = (wr_i && stat_we_en) ? stat_hit :
		{`EMST_STAT_COUNT{1'b0}}; // (R4)
	wire [23:0]                 stat_val [0:`EMST_STAT_COUNT-1];

	genvar g;
	generate
		// Each counter has its own width; bits above it read zero
		for (g = 0; g < `EMST_STAT_COUNT; g = g + 1) begin : g_stat
			emst_stat_counter #(
				.WIDTH (stat_width(g))
			) u_cnt (
				.clk_i   (clk_i),
				.rst_b_i (rst_b_i),
				.ce_i    (ce_i),
				.inc_i   (stat_inc[g]),
				.clr_i   (rd_sel[g]), // (R1)
				.wr_i    (wr_sel[g]),
				.wdata_i (wdata_i[23:0]),
				.count_o (stat_val[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Read path

	reg [31:0] next_rdata;
	integer    j;

	always @* begin
		next_rdata = 32'h0000_0000;
		if (ctrl_hit[CTRL_NET]) begin
			next_rdata = net_ctrl;
		end else if (ctrl_hit[CTRL_CFG]) begin
			next_rdata = net_cfg;
		end else if (ctrl_hit[CTRL_SA4L]) begin
			next_rdata = specific_addr4_low;
		end else if (ctrl_hit[CTRL_SA4H]) begin
			next_rdata = {16'h0000, specific_addr4_high}; // (R20)
		end else if (ctrl_hit[CTRL_TYPE]) begin
			next_rdata = {16'h0000, type_match_field};
		end else if (ctrl_hit[CTRL_UIO]) begin
			next_rdata = {30'h0000000, phy_clock_gate, rmii_sel};
		end else begin
			// Gaps and unmapped addresses fall through as zero
			for (j = 0; j < `EMST_STAT_COUNT; j = j + 1) begin
				if (stat_hit == (9'h001 << j)) begin
					next_rdata = {8'h00, stat_val[j]}; // (R1)
				end
			end
		end
	end

	// Value shows one cycle after the strobe; the counter clears on the same edge
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// Address and type matching

	wire [47:0] addr4     = {specific_addr4_high, specific_addr4_low};
	wire        addr4_hit = (rx_dest_i == addr4); // (R6)
	wire        type_hit  = (rx_type_i == type_match_field); // (R7)

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			match_valid_o <= 1'b0;
			addr4_match_o <= 1'b0;
			type_match_o  <= 1'b0;
		end else if (ce_i) begin
			match_valid_o <= rx_done_i;
			if (rx_done_i) begin
				// Byte 0 sits in bits 7:0, so bit 0 is the group bit of the first byte
				addr4_match_o <= addr4_hit; // (R6)
				type_match_o  <= type_hit; // (R7)
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Transceiver side

	wire phy_clk_s;

	emst_sync2 u_phy_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.async_i (phy_clk_i),
		.sync_o  (phy_clk_s)
	);

	// A gate write in a high phase cuts that pulse short; the output is a
	// sampled level, not a glitch-free clock
	wire phy_clk_run = phy_clk_s && phy_clock_gate; // (R9)

	// Sampled copy of the transceiver clock; only valid while the
	// transceiver clock stays well below half the system clock
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rmii_mode_o     <= 1'b0;
			phy_clk_gated_o <= 1'b0;
			rx_enable_o     <= 1'b0;
			big_frames_o    <= 1'b0;
		end else if (ce_i) begin
			rmii_mode_o     <= rmii_sel; // (R8)
			phy_clk_gated_o <= phy_clk_run; // (R9)
			rx_enable_o     <= rx_en;
			big_frames_o    <= big_en;
		end
	end

endmodule

`default_nettype wire

// [testbench/emst_phy_model.sv]
`timescale 1ns/1ps
`default_nettype none
module emst_phy_model #(
	parameter int HALF_NS = 160
) (
	// Transceiver clock toward the device
	output var logic clk_o
);
	// Odd start offset keeps its edges off the system clock edges
	initial begin
		clk_o = 1'b0;
		#7;
		forever #(HALF_NS) clk_o = ~clk_o;
	end
endmodule
`default_nettype wire

// [testbench/emst_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module emst_top_sva (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        ce_i,
	// Register port
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Frame reports
	input wire logic        rx_done_i,
	input wire logic        tx_done_i,
	// Results and controls
	input wire logic        match_valid_o,
	input wire logic        addr4_match_o,
	input wire logic        type_match_o,
	input wire logic        rx_enable_o,
	input wire logic        big_frames_o,
	input wire logic        rmii_mode_o,
	input wire logic        phy_clk_gated_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////
	property p_rd_clear;
		ce_i && rd_i && addr_i == 8'h1C && !tx_done_i ##1 !tx_done_i && !wr_i
			##1 rd_i && addr_i == 8'h1C && !tx_done_i |=> rdata_o == 32'h0;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("counter not cleared by read");
	property p_idle_zero;
		ce_i && !rd_i |=> rdata_o == 32'h0;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside read");
	// Enable output lags the control bit by one cycle, hence the check in cycle two
	property p_rx_hold;
		ce_i && rd_i && addr_i == 8'h28 ##1 !wr_i && !rx_enable_o
			##1 rd_i && addr_i == 8'h28 && !rx_enable_o |=> rdata_o == 32'h0;
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx count moved while disabled");
	property p_match_pulse;
		ce_i |=> match_valid_o == $past(rx_done_i);
	endproperty
	a_match_pulse: assert property (p_match_pulse) else $error("match pulse wrong");
	property p_addr_hold;
		!rx_done_i |=> $stable(addr4_match_o);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address match moved");
	property p_type_hold;
		!rx_done_i |=> $stable(type_match_o);
	endproperty
	a_type_hold: assert property (p_type_hold) else $error("type match moved");
	property p_rmii;
		ce_i && wr_i && addr_i == 8'h14 ##1 (ce_i && !wr_i) [*2]
			|-> rmii_mode_o == $past(wdata_i[0], 2);
	endproperty
	a_rmii: assert property (p_rmii) else $error("mode select wrong");
	property p_clk_gate;
		ce_i && wr_i && addr_i == 8'h14 && !wdata_i[1] ##1 (ce_i && !wr_i) [*4]
			|-> !phy_clk_gated_o;
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("gated clock runs");
	property p_big;
		ce_i && wr_i && addr_i == 8'h04 ##1 (ce_i && !wr_i) [*2]
			|-> big_frames_o == $past(wdata_i[8], 2);
	endproperty
	a_big: assert property (p_big) else $error("big frame flag wrong");
	property p_high_rsvd;
		ce_i && rd_i && addr_i == 8'h0C |=> rdata_o[31:16] == 16'h0;
	endproperty
	a_high_rsvd: assert property (p_high_rsvd) else $error("reserved bits set");
	c_rx: cover property (ce_i && rx_done_i);
	c_tx: cover property (ce_i && tx_done_i);
	c_rd: cover property (rd_i && addr_i == 8'h18);
endmodule
bind emst_top emst_top_sva u_sva (.clk_i, .rst_b_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .rx_done_i, .tx_done_i, .match_valid_o, .addr4_match_o, .type_match_o,
	.rx_enable_o, .big_frames_o, .rmii_mode_o, .phy_clk_gated_o);
`default_nettype wire

// [testbench/emst_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module emst_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ce = 1'b1;
	logic        rxd = 1'b0;
	logic [15:0] rxw = 16'h0;
	logic [47:0] dest = 48'h0;
	logic [15:0] rtype = 16'h0;
	logic        txd = 1'b0;
	logic [8:0]  txw = 9'h0;
	logic [31:0] rdata;
	logic        mv, am, tm, rxen, big, rmii, pclk_g, pclk;
	int          fails = 0;
	int          checked = 0;
	int          i, n;
	// Length, then crc, odd bits, symbol, pause, copied
	logic [15:0] rtab [9] = '{{11'h040, 5'h03}, {11'h5EE, 5'h01}, {11'h5EF, 5'h01},
		{11'h03F, 5'h01}, {11'h064, 5'h10}, {11'h064, 5'h04}, {11'h064, 5'h18},
		{11'h064, 5'h0C}, {11'h064, 5'h02}};
	// Collisions, then underrun, retry fail, late, deferred
	logic [8:0]  ttab [13] = '{{5'h00, 4'h0}, {5'h01, 4'h0}, {5'h00, 4'h2}, {5'h02, 4'h0},
		{5'h0F, 4'h0}, {5'h0E, 4'h2}, {5'h0F, 4'h2}, {5'h01, 4'h8}, {5'h02, 4'h4},
		{5'h00, 4'h1}, {5'h01, 4'h1}, {5'h00, 4'h3}, {5'h00, 4'h9}};
	always #20 clk_i = ~clk_i;
	emst_phy_model phy (.clk_o(pclk));
	emst_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_done_i(rxd),
		.rx_len_i(rxw[15:5]), .rx_crc_bad_i(rxw[4]), .rx_odd_bits_i(rxw[3]),
		.rx_sym_err_i(rxw[2]), .rx_pause_i(rxw[1]), .rx_copied_i(rxw[0]),
		.rx_dest_i(dest), .rx_type_i(rtype), .tx_done_i(txd), .tx_underrun_i(txw[3]),
		.tx_retry_fail_i(txw[2]), .tx_collisions_i(txw[8:4]), .tx_late_col_i(txw[1]),
		.tx_deferred_i(txw[0]), .match_valid_o(mv), .addr4_match_o(am),
		.type_match_o(tm), .rx_enable_o(rxen), .big_frames_o(big), .phy_clk_i(pclk),
		.rmii_mode_o(rmii), .phy_clk_gated_o(pclk_g));
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk($sformatf("reg %h", a), rdata, e);
	endtask
	task automatic rx(input logic [15:0] w);
		@(posedge clk_i);
		rxw <= w;
		rxd <= 1'b1;
		@(posedge clk_i);
		rxd <= 1'b0;
		#1;
	endtask
	task automatic tx(input logic [8:0] w);
		@(posedge clk_i);
		txw <= w;
		txd <= 1'b1;
		@(posedge clk_i);
		txd <= 1'b0;
	endtask
	task automatic results();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (i = 0; i < 16; i++)
			rdc(8'(i * 4), 32'h0);
		$display("reset values done");
		wrr(8'h08, 32'h1234_5679);
		wrr(8'h0C, 32'hFFFF_ABCD);
		wrr(8'h10, 32'hFFFF_0800);
		wrr(8'h14, 32'hFFFF_FFFF);
		wrr(8'h3C, 32'hFFFF_FFFF);
		rdc(8'h08, 32'h1234_5679);
		rdc(8'h0C, 32'h0000_ABCD);
		rdc(8'h10, 32'h0000_0800);
		rdc(8'h14, 32'h0000_0003);
		rdc(8'h3C, 32'h0);
		chk("rmii", rmii, 32'h1);
		$display("registers done");
		dest <= 48'hABCD_1234_5679;
		rtype <= 16'h0800;
		rx({11'h040, 5'h03});
		chk("match", {mv, am, tm}, 32'h7);
		dest <= 48'hABCD_1234_5678;
		rtype <= 16'h0801;
		rx({11'h040, 5'h03});
		chk("match", {mv, am, tm}, 32'h4);
		rdc(8'h28, 32'h0);
		rdc(8'h28, 32'h0);
		rdc(8'h18, 32'h0);
		$display("match done");
		wrr(8'h00, 32'h0000_0084);
		for (i = 0; i < 9; i++)
			rx(rtab[i]);
		rdc(8'h18, 32'h2);
		rdc(8'h28, 32'h2);
		rdc(8'h2C, 32'h2);
		rdc(8'h30, 32'h2);
		chk("rx enable", rxen, 32'h1);
		wrr(8'h04, 32'h0000_0100);
		rx({11'h600, 5'h01});
		rx({11'h601, 5'h01});
		rdc(8'h28, 32'h1);
		chk("big", big, 32'h1);
		$display("receive counts done");
		for (i = 0; i < 13; i++)
			tx(ttab[i]);
		rdc(8'h1C, 32'hA);
		rdc(8'h20, 32'h4);
		rdc(8'h24, 32'h3);
		rdc(8'h34, 32'h1);
		rdc(8'h38, 32'h4);
		rdc(8'h1C, 32'h0);
		rdc(8'h1C, 32'h0);
		$display("transmit counts done");
		wrr(8'h2C, 32'hFFFF_FFFE);
		rdc(8'h2C, 32'h0000_00FE);
		wrr(8'h2C, 32'h0000_00FE);
		rx({11'h064, 5'h10});
		rx({11'h064, 5'h10});
		rdc(8'h2C, 32'h0000_00FF);
		rdc(8'h2C, 32'h0);
		wrr(8'h00, 32'h0000_0004);
		wrr(8'h2C, 32'h0000_0055);
		rdc(8'h2C, 32'h0);
		$display("saturation done");
		n = 0;
		repeat (64) @(negedge clk_i) n += pclk_g;
		chk("clock runs", 32'(n > 8 && n < 56), 32'h1);
		wrr(8'h14, 32'h0);
		repeat (4) @(posedge clk_i);
		n = 0;
		repeat (64) @(negedge clk_i) n += pclk_g;
		chk("clock stopped", 32'(n), 32'h0);
		chk("rmii", rmii, 32'h0);
		$display("transceiver done");
		@(posedge clk_i);
		ce <= 1'b0;
		wrr(8'h14, 32'h0000_0001);
		rx({11'h064, 5'h10});
		@(posedge clk_i);
		ce <= 1'b1;
		rdc(8'h14, 32'h0);
		rdc(8'h2C, 32'h0);
		chk("rmii", rmii, 32'h0);
		$display("clock enable done");
		results();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		fails++;
		results();
	end
endmodule
`default_nettype wire
